/* shared/adc_cfg_pkg.sv */
// Package: register map, field positions, reset values and serial framing constants
package adc_cfg_pkg;
  localparam logic [7:0] ADDR_RESET_READBACK = 8'h00;
  localparam logic [7:0] ADDR_DISTORTION     = 8'h02;
  localparam logic [7:0] ADDR_FORMAT         = 8'h3c;
  localparam logic [7:0] ADDR_PATTERN_HIGH   = 8'h3e;
  localparam logic [7:0] ADDR_PATTERN_LOW    = 8'h3f;
  localparam logic [7:0] ADDR_REF_POWER      = 8'h44;
  localparam logic [7:0] ADDR_GAIN           = 8'h45;

  localparam int BIT_READBACK        = 0;
  localparam int BIT_SOFT_INIT       = 1;
  localparam int BIT_FORMAT_SOURCE   = 7;
  localparam int BIT_FORMAT_VALUE    = 6;
  localparam int BIT_REF_SOURCE      = 3;
  localparam int BIT_REF_VALUE       = 2;
  localparam int BIT_SOFT_POWERDOWN  = 6;
  localparam int GAIN_LSB            = 4;
  localparam int GAIN_WIDTH          = 4;
  localparam int PATTERN_LOW_LSB     = 2;
  localparam int PATTERN_WIDTH       = 14;

  // Writable bits per register
  localparam logic [7:0] MASK_RESET_READBACK = 8'h01;
  localparam logic [7:0] MASK_DISTORTION     = 8'h71;
  localparam logic [7:0] MASK_FORMAT         = 8'hc0;
  localparam logic [7:0] MASK_PATTERN_HIGH   = 8'hff;
  localparam logic [7:0] MASK_PATTERN_LOW    = 8'hfc;
  localparam logic [7:0] MASK_REF_POWER      = 8'h4c;
  localparam logic [7:0] MASK_GAIN           = 8'hf0;

  localparam logic [7:0] RESET_VALUE         = 8'h00;

  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 8;
endpackage : adc_cfg_pkg

/* rtl/pin_sync.sv */
// Three-stage input synchroniser with agreement-based change detection
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int  WIDTH    = 1,
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  generate
    if (WIDTH < 1) begin : g_bad
      $error("pin_sync: WIDTH must be at least one");
    end
  endgenerate

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 feeds only stage2; decisions use stage2 and stage3 agreeing
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1 <= {WIDTH{RESET_LEVEL}};
      stage2 <= {WIDTH{RESET_LEVEL}};
      stage3 <= {WIDTH{RESET_LEVEL}};
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          level[i] <= RESET_LEVEL;
          rise[i]  <= 1'b0;
          fall[i]  <= 1'b0;
        end else begin
          rise[i] <= (stage2[i] == stage3[i]) && stage3[i] && !level[i];
          fall[i] <= (stage2[i] == stage3[i]) && !stage3[i] && level[i];
          if (stage2[i] == stage3[i]) begin
            level[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

/* rtl/adc_config_register_bank.sv */
// Serial-port configuration register bank of the converter
//
// Summary of operation
// - Writing one to bit 1 at address 00 resets every configuration register to the value the reset input gives it.
// - Bit 0 at address 00 resets to zero for writes and, when one, turns serial words into reads.
// - Bit 7 at address 3C picks the output format from the strap pin when zero, the register when one.
// - Bit 6 at address 3C gives twos complement when zero and offset binary when one, used only under override.
// - Address 3E holds the upper eight bits of the 14-bit user pattern.
// - Bits 7 to 2 at address 3F hold the lower six pattern bits; bits 1 and 0 are not stored.
// - Bit 3 at address 44 picks the reference choice from the strap pin when zero, the register when one.
// - Bit 2 at address 44 picks internal reference when zero and external when one, used only under override.
// - Bits 7 to 4 at address 45 set fine gain from 0 dB to 6 dB in half-dB steps, default 0 dB.
// - Each word is 16 bits taken on falling serial clock edges with select low, address then data.
// - After a software reset the soft initialization bit returns to zero by itself.
// - While readback is set, only writes to the readback bit at address 00 are accepted.
// - During a read the addressed register's eight bits are shifted out on the readback pin.
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // Serial port pins
  input  wire logic                  serial_clk,
  input  wire logic                  serial_select_n,
  input  wire logic                  serial_in_line,
  output logic                       readback_out_pin,
  // Strap pin
  input  wire logic                  format_refsel_pin,
  // Configuration outputs
  output logic                       readback_mode,
  output logic [7:0]                 distortion_tuning_bits,
  output logic                       output_format_choice,
  output logic                       external_reference,
  output logic [PATTERN_WIDTH-1:0]   user_test_pattern,
  output logic                       soft_powerdown,
  output logic [GAIN_WIDTH-1:0]      fine_gain
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The four-bit word counter and the fixed slices below only serve
  // a 16-bit word split evenly into an address byte and a data byte
  generate
    if (WORD_BITS != 16) begin : g_bad_word
      $error("adc_config_register_bank: word must be 16 bits");
    end
    if (ADDR_BITS + DATA_BITS != WORD_BITS) begin : g_bad_split
      $error("adc_config_register_bank: address and data must fill the word");
    end
    if (ADDR_BITS != 8 || DATA_BITS != 8) begin : g_bad_byte
      $error("adc_config_register_bank: address and data must be eight bits");
    end
    if (GAIN_LSB + GAIN_WIDTH > DATA_BITS) begin : g_bad_gain
      $error("adc_config_register_bank: gain field leaves its register");
    end
    if (PATTERN_WIDTH != 2 * DATA_BITS - PATTERN_LOW_LSB) begin : g_bad_pattern
      $error("adc_config_register_bank: pattern width does not fit its registers");
    end
    if (BIT_FORMAT_SOURCE >= DATA_BITS || BIT_FORMAT_VALUE >= DATA_BITS ||
        BIT_REF_SOURCE >= DATA_BITS || BIT_REF_VALUE >= DATA_BITS ||
        BIT_SOFT_POWERDOWN >= DATA_BITS) begin : g_bad_bit
      $error("adc_config_register_bank: control bit outside its register");
    end
    if (BIT_READBACK >= DATA_BITS || BIT_SOFT_INIT >= DATA_BITS) begin : g_bad_ctrl
      $error("adc_config_register_bank: reset or readback bit outside its register");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic       sclk_level;
  logic       sclk_fall;
  logic       sel_n_level;
  logic       serial_in_line_level;
  logic       strap_level;
  logic [3:0] sync_level;
  logic [3:0] sync_fall;

  // Select idles high so reset must not fake a frame start
  pin_sync #(
    .WIDTH       (4),
    .RESET_LEVEL (1'b0)
  ) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin_in  ({format_refsel_pin, serial_in_line, ~serial_select_n, serial_clk}),
    .level   (sync_level),
    .rise    (),
    .fall    (sync_fall)
  );

  assign sclk_level  = sync_level[0];
  assign sclk_fall   = sync_fall[0];
  assign sel_n_level = ~sync_level[1];
  assign serial_in_line_level = sync_level[2];
  assign strap_level = sync_level[3];

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  logic [WORD_BITS-2:0] shift_reg;
  logic [3:0]           bit_count;
  logic                 word_done;
  logic [7:0]           word_addr;
  logic [7:0]           word_data;
  logic [7:0]           read_addr;

  assign word_done = sclk_fall && !sel_n_level && (bit_count == 4'(WORD_BITS - 1));
  assign word_addr = shift_reg[WORD_BITS-2:DATA_BITS-1];
  assign word_data = {shift_reg[DATA_BITS-2:0], serial_in_line_level};
  assign read_addr = {shift_reg[DATA_BITS-2:0], serial_in_line_level};

  // Excess bits past a multiple of 16 are dropped when select rises
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_reg <= '0;
      bit_count <= '0;
    end else if (sel_n_level) begin
      bit_count <= '0;
    end else if (sclk_fall) begin
      shift_reg <= {shift_reg[WORD_BITS-3:0], serial_in_line_level};
      bit_count <= bit_count + 4'd1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic       readback;
  logic [7:0] distortion;
  logic [7:0] format_ctrl;
  logic [7:0] pattern_high;
  logic [7:0] pattern_low;
  logic [7:0] ref_power;
  logic [7:0] gain_ctrl;
  logic       soft_init;
  logic       write_ok;

  // Writes land on the 16th falling edge; address 00 always accepted
  assign write_ok = word_done && (!readback || word_addr == ADDR_RESET_READBACK);

  // Soft init is a one-cycle pulse: it resets every configuration register on the next
  // clock and then reads back as zero with no software action.
  // Readback locks it out: only bit 0 of address 00 may change then,
  // otherwise a stray init would wipe the bank during a diagnostic read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      soft_init <= 1'b0;
    end else begin
      soft_init <= write_ok && !readback && word_addr == ADDR_RESET_READBACK
                   && word_data[BIT_SOFT_INIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || soft_init) begin
      readback     <= RESET_VALUE[0];
      distortion   <= RESET_VALUE;
      format_ctrl  <= RESET_VALUE;
      pattern_high <= RESET_VALUE;
      pattern_low  <= RESET_VALUE;
      ref_power    <= RESET_VALUE;
      gain_ctrl    <= RESET_VALUE;
    end else if (write_ok) begin
      case (word_addr)
        ADDR_RESET_READBACK: readback     <= word_data[BIT_READBACK];
        ADDR_DISTORTION:     distortion   <= word_data & MASK_DISTORTION;
        ADDR_FORMAT:         format_ctrl  <= word_data & MASK_FORMAT;
        ADDR_PATTERN_HIGH:   pattern_high <= word_data & MASK_PATTERN_HIGH;
        ADDR_PATTERN_LOW:    pattern_low  <= word_data & MASK_PATTERN_LOW;
        ADDR_REF_POWER:      ref_power    <= word_data & MASK_REF_POWER;
        ADDR_GAIN:           gain_ctrl    <= word_data & MASK_GAIN;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  logic [7:0] read_value;
  logic [7:0] out_shift;

  always_comb begin
    case (read_addr)
      ADDR_RESET_READBACK: read_value = {7'h00, readback};
      ADDR_DISTORTION:     read_value = distortion;
      ADDR_FORMAT:         read_value = format_ctrl;
      ADDR_PATTERN_HIGH:   read_value = pattern_high;
      ADDR_PATTERN_LOW:    read_value = pattern_low;
      ADDR_REF_POWER:      read_value = ref_power;
      ADDR_GAIN:           read_value = gain_ctrl;
      default:             read_value = 8'h00;
    endcase
  end

  // Address completes on the 8th fall; data bits move out on the
  // following rising edges so the controller samples them on falls
  logic sclk_rise_seen;
  logic sclk_prev;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_level;
    end
  end
  assign sclk_rise_seen = sclk_level && !sclk_prev;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_shift <= '0;
    end else if (sel_n_level || !readback) begin
      out_shift <= '0;
    end else if (sclk_fall && bit_count == 4'(ADDR_BITS - 1)) begin
      out_shift <= read_value;
    end else if (sclk_rise_seen && bit_count > 4'(ADDR_BITS)) begin
      out_shift <= {out_shift[6:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      readback_out_pin <= 1'b0;
    end else begin
      readback_out_pin <= readback && !sel_n_level && out_shift[7];
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  // One strap pin serves both the format and the reference choice;
  // each override bit swaps the pin for its own register bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      output_format_choice <= 1'b0;
      external_reference   <= 1'b0;
    end else begin
      output_format_choice <= format_ctrl[BIT_FORMAT_SOURCE] ?
                              format_ctrl[BIT_FORMAT_VALUE] : strap_level;
      external_reference   <= ref_power[BIT_REF_SOURCE] ?
                              ref_power[BIT_REF_VALUE] : strap_level;
    end
  end

  assign readback_mode          = readback;
  assign distortion_tuning_bits = distortion;
  assign user_test_pattern      = {pattern_high, pattern_low[7:PATTERN_LOW_LSB]};
  assign soft_powerdown         = ref_power[BIT_SOFT_POWERDOWN];
  assign fine_gain              = gain_ctrl[GAIN_LSB +: GAIN_WIDTH];

endmodule : adc_config_register_bank
`default_nettype wire

/* testbench/adc_cfg_ctrl_model.sv */
// Controller model for the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_ctrl_model (
  // Clock
  input  wire logic sys_clk,
  // Serial port
  output logic      serial_clk,
  output logic      serial_select_n,
  output logic      serial_in_line,
  input  wire logic readback_out_pin
);
  initial begin
    serial_clk = 1'b1;
    serial_select_n = 1'b1;
    serial_in_line = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_clk
  // Sends nb bits MSB first; ph is half a serial period in system clocks
  task automatic frame(input logic [31:0] w, input int nb, input int ph,
                       output logic [7:0] rd);
    rd = 8'h00;
    @(negedge sys_clk);
    serial_select_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      serial_in_line = w[31-i];
      wait_clk(ph);
      if (i >= 8 && i < 16) rd = {rd[6:0], readback_out_pin};
      serial_clk = 1'b0;
      wait_clk(ph);
      serial_clk = 1'b1;
    end
    wait_clk(ph);
    serial_select_n = 1'b1;
    // Released line must not keep showing the last bit
    serial_in_line = ~serial_in_line;
  endtask : frame
endmodule : adc_cfg_ctrl_model
`default_nettype wire

/* testbench/adc_config_register_bank_sva.sv */
// Port checker for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_sva
  import adc_cfg_pkg::*;
(
  input wire logic                     sys_clk,
  input wire logic                     sys_rst,
  input wire logic                     serial_clk,
  input wire logic                     serial_select_n,
  input wire logic                     serial_in_line,
  input wire logic                     readback_out_pin,
  input wire logic                     format_refsel_pin,
  input wire logic                     readback_mode,
  input wire logic [7:0]               distortion_tuning_bits,
  input wire logic                     output_format_choice,
  input wire logic                     external_reference,
  input wire logic [PATTERN_WIDTH-1:0] user_test_pattern,
  input wire logic                     soft_powerdown,
  input wire logic [GAIN_WIDTH-1:0]    fine_gain
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [26:0] cfg;
  logic [3:0]  idle_cnt;
  logic [3:0]  since_fall;
  logic        clk_q;
  assign cfg = {distortion_tuning_bits, user_test_pattern, soft_powerdown, fine_gain};
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !serial_select_n) idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hf) idle_cnt <= idle_cnt + 4'h1;
  end
  always_ff @(posedge sys_clk) begin
    clk_q <= serial_clk;
    if (sys_rst) since_fall <= 4'hf;
    else if (clk_q && !serial_clk) since_fall <= 4'h0;
    else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
  end
  property p_mask; (distortion_tuning_bits & ~MASK_DISTORTION) == 8'h00; endproperty
  property p_reset_clears;
    disable iff (1'b0) sys_rst |=> cfg == 27'h000_0000 && !readback_mode;
  endproperty
  property p_idle_hold; idle_cnt >= 4'ha |-> $stable(cfg) && $stable(readback_mode); endproperty
  property p_idle_quiet; idle_cnt >= 4'ha |-> !readback_out_pin; endproperty
  property p_lock; readback_mode && $past(readback_mode) |-> $stable(cfg); endproperty
  property p_gain_cause; $changed(fine_gain) |-> since_fall <= 4'hc; endproperty
  property p_mode_cause; $changed(readback_mode) |-> since_fall <= 4'hc; endproperty
  property p_write_quiet;
    $fell(serial_select_n) && !readback_mode |-> !readback_out_pin [*8];
  endproperty
  a_mask: assert property (p_mask) else $error("reserved bit set");
  a_reset_clears: assert property (p_reset_clears) else $error("reset left state");
  a_idle_hold: assert property (p_idle_hold) else $error("idle change");
  a_idle_quiet: assert property (p_idle_quiet) else $error("pin busy idle");
  a_lock: assert property (p_lock) else $error("write in readback");
  a_gain_cause: assert property (p_gain_cause) else $error("gain moved alone");
  a_mode_cause: assert property (p_mode_cause) else $error("mode moved alone");
  a_write_quiet: assert property (p_write_quiet) else $error("pin busy on write");
  c_read: cover property ($rose(readback_mode));
  c_gain: cover property ($changed(fine_gain));
  c_fmt: cover property ($rose(output_format_choice));
endmodule : adc_config_register_bank_sva
bind adc_config_register_bank adc_config_register_bank_sva chk_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
  .serial_select_n(serial_select_n), .serial_in_line(serial_in_line),
  .readback_out_pin(readback_out_pin), .format_refsel_pin(format_refsel_pin),
  .readback_mode(readback_mode), .distortion_tuning_bits(distortion_tuning_bits),
  .output_format_choice(output_format_choice), .external_reference(external_reference),
  .user_test_pattern(user_test_pattern), .soft_powerdown(soft_powerdown),
  .fine_gain(fine_gain));
`default_nettype wire

/* testbench/adc_config_register_bank_test.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_test import adc_cfg_pkg::*;;
  logic sys_clk, sys_rst, serial_clk, serial_select_n, serial_in_line, readback_out_pin;
  logic format_refsel_pin, readback_mode, output_format_choice, external_reference;
  logic soft_powerdown;
  logic [7:0] distortion_tuning_bits, rd;
  logic [13:0] user_test_pattern;
  logic [3:0] fine_gain;
  int n_errors = 0;
  int checks = 0;
  logic [7:0] addr [6] = '{8'h02, 8'h3c, 8'h3e, 8'h3f, 8'h44, 8'h45};
  logic [7:0] mask [6] = '{MASK_DISTORTION, MASK_FORMAT, MASK_PATTERN_HIGH,
                           MASK_PATTERN_LOW, MASK_REF_POWER, MASK_GAIN};
  adc_config_register_bank dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_in_line(serial_in_line), .readback_out_pin(readback_out_pin),
    .format_refsel_pin(format_refsel_pin), .readback_mode(readback_mode),
    .distortion_tuning_bits(distortion_tuning_bits),
    .output_format_choice(output_format_choice), .external_reference(external_reference),
    .user_test_pattern(user_test_pattern), .soft_powerdown(soft_powerdown),
    .fine_gain(fine_gain));
  adc_cfg_ctrl_model ctrl_u (.sys_clk(sys_clk), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_in_line(serial_in_line),
    .readback_out_pin(readback_out_pin));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ctrl_u.frame({a, d, 16'h0000}, 16, 4, rd);
    repeat (12) @(negedge sys_clk);
  endtask : wr
  // Slow serial clock on reads leaves room for the synchroniser delay
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    ctrl_u.frame({a, 8'h00, 16'h0000}, 16, 8, rd);
    repeat (12) @(negedge sys_clk);
    chk("readback", 16'(exp), 16'(rd));
  endtask : rdchk
  task automatic give_verdict;
    $display("n_errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #1_000_000;
    n_errors++;
    give_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    format_refsel_pin = 1'b1;
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("gain", 16'h0000, 16'(fine_gain));
    chk("mode", 16'h0000, 16'(readback_mode));
    chk("format", 16'h0001, 16'(output_format_choice));
    chk("ref", 16'h0001, 16'(external_reference));
    format_refsel_pin = 1'b0;
    for (int i = 0; i < 6; i++) wr(addr[i], 8'hff);
    chk("tuning", 16'h0071, 16'(distortion_tuning_bits));
    chk("pattern", 16'h3fff, 16'(user_test_pattern));
    chk("powerdown", 16'h0001, 16'(soft_powerdown));
    chk("format", 16'h0001, 16'(output_format_choice));
    chk("ref", 16'h0001, 16'(external_reference));
    wr(ADDR_RESET_READBACK, 8'h01);
    chk("mode", 16'h0001, 16'(readback_mode));
    for (int i = 0; i < 6; i++) rdchk(addr[i], mask[i]);
    rdchk(8'h10, 8'h00);
    wr(ADDR_GAIN, 8'h00);
    chk("gain", 16'h000f, 16'(fine_gain));
    // Soft init bit is locked out as well while reads are on
    wr(ADDR_RESET_READBACK, 8'h03);
    chk("gain", 16'h000f, 16'(fine_gain));
    chk("mode", 16'h0001, 16'(readback_mode));
    wr(ADDR_RESET_READBACK, 8'h00);
    chk("mode", 16'h0000, 16'(readback_mode));
    format_refsel_pin = 1'b1;
    wr(ADDR_FORMAT, 8'h80);
    wr(ADDR_REF_POWER, 8'h08);
    chk("format", 16'h0000, 16'(output_format_choice));
    chk("ref", 16'h0000, 16'(external_reference));
    wr(ADDR_PATTERN_HIGH, 8'ha5);
    wr(ADDR_PATTERN_LOW, 8'h5a);
    chk("pattern", 16'({8'ha5, 6'h16}), 16'(user_test_pattern));
    ctrl_u.frame({ADDR_GAIN, 8'h90, ADDR_PATTERN_HIGH, 8'h3c}, 32, 8, rd);
    repeat (12) @(negedge sys_clk);
    chk("gain", 16'h0009, 16'(fine_gain));
    chk("pattern", 16'({8'h3c, 6'h16}), 16'(user_test_pattern));
    ctrl_u.frame({ADDR_GAIN, 8'h30, 16'h0000}, 12, 4, rd);
    repeat (12) @(negedge sys_clk);
    chk("gain", 16'h0009, 16'(fine_gain));
    wr(ADDR_RESET_READBACK, 8'h02);
    chk("pattern", 16'h0000, 16'(user_test_pattern));
    chk("gain", 16'h0000, 16'(fine_gain));
    chk("tuning", 16'h0000, 16'(distortion_tuning_bits));
    wr(ADDR_RESET_READBACK, 8'h01);
    rdchk(ADDR_RESET_READBACK, 8'h01);
    wr(ADDR_RESET_READBACK, 8'h00);
    wr(ADDR_GAIN, 8'hf0);
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk("gain", 16'h0000, 16'(fine_gain));
    give_verdict();
  end
endmodule : adc_config_register_bank_test
`default_nettype wire
